// file: hdl/pdmc_pkg.sv
// package: register map, field layout and constants of the power-down mode controller
package pdmc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] SYSTEM_POWER_CONTROL_ADDR = 16'hffc4;
    localparam logic [7:0] SYSTEM_POWER_CONTROL_RESET = 8'h09;
    localparam int SOFT_STANDBY_SELECT_BIT = 7;
    localparam int WAKE_SETTLE_SELECT_HI = 6;
    localparam int WAKE_SETTLE_SELECT_LO = 4;
    localparam int RESET_SOURCE_FLAG_BIT = 3;
    localparam int NMI_EDGE_SELECT_BIT = 2;
    localparam int HOST_IF_ENABLE_BIT = 1;
    localparam int ONCHIP_RAM_ENABLE_BIT = 0;

    // ------------------------------------------------------------
    // settling counts in states
    // ------------------------------------------------------------
    localparam logic [17:0] SETTLE_8K = 18'h02000;
    localparam logic [17:0] SETTLE_16K = 18'h04000;
    localparam logic [17:0] SETTLE_32K = 18'h08000;
    localparam logic [17:0] SETTLE_64K = 18'h10000;
    localparam logic [17:0] SETTLE_128K = 18'h20000;
    localparam logic [17:0] SETTLE_1K = 18'h00400;

    // ------------------------------------------------------------
    // power states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        PDMC_RUN = 5'h01,
        PDMC_SLEEP = 5'h02,
        PDMC_SSTBY = 5'h04,
        PDMC_SETTLE = 5'h08,
        PDMC_HSTBY = 5'h10
    } pdmc_state_e;

    typedef struct packed {
        logic soft_standby_select;
        logic [2:0] wake_settle_select;
        logic reset_source_flag;
        logic nmi_edge_select;
        logic host_if_enable;
        logic onchip_ram_enable;
    } pdmc_ctrl_s;

endpackage

// file: hdl/pdmc_top.sv
// power-down mode controller: sleep, software standby and hardware standby sequencing
//
// Implementation choice: strobed register access.
module pdmc_top
    import pdmc_pkg::*;
#(
    parameter bit FLASH_VARIANT = 1'b0
) (
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic [15:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic POWER_DOWN_EXEC,
    input wire logic IRQ_PENDING,
    input wire logic WAKE_EXT_IRQ,
    input wire logic CHIP_RESET_PIN_N,
    input wire logic HW_STANDBY_PIN_N,
    input wire logic RESET_SOURCE_IN,
    output logic CPU_HALT,
    output logic PERIPH_HALT,
    output logic PERIPH_RESET,
    output logic CLOCK_STOP,
    output logic OSC_ENABLE,
    output logic PORTS_HIZ,
    output logic WAKE_DONE,
    output logic [4:0] POWER_STATE
);

    // ------------------------------------------------------------
    // settling count decode
    // ------------------------------------------------------------
    function automatic logic [17:0] settle_count(input logic [2:0] sel);
        logic [17:0] n;
        n = SETTLE_8K;
        unique case (sel)
            3'h0: n = SETTLE_8K;
            3'h1: n = SETTLE_16K;
            3'h2: n = SETTLE_32K;
            3'h3: n = SETTLE_64K;
            3'h4: n = SETTLE_128K;
            3'h5: n = FLASH_VARIANT ? SETTLE_1K : SETTLE_128K;
            // codes 11x are unused and fall back to the longest count
            default: n = SETTLE_128K;
        endcase
        return n;
    endfunction

    // ------------------------------------------------------------
    // system power control register
    // ------------------------------------------------------------
    pdmc_ctrl_s ctrl_q, ctrl_d;
    logic [7:0] rdata_q, rdata_d;
    logic hit;
    logic wr_hit;
    logic rd_hit;

    // unmapped addresses read as zero and ignore writes
    assign hit = (REG_ADDR == SYSTEM_POWER_CONTROL_ADDR);
    assign wr_hit = REG_WR && hit;
    assign rd_hit = REG_RD && hit;

    always_comb begin
        ctrl_d = ctrl_q;
        // read-only flag follows the reset source every cycle
        ctrl_d.reset_source_flag = RESET_SOURCE_IN;
        if (wr_hit) begin
            ctrl_d.soft_standby_select = REG_WDATA[SOFT_STANDBY_SELECT_BIT];
            ctrl_d.wake_settle_select =
                REG_WDATA[WAKE_SETTLE_SELECT_HI:WAKE_SETTLE_SELECT_LO];
            ctrl_d.nmi_edge_select = REG_WDATA[NMI_EDGE_SELECT_BIT];
            ctrl_d.host_if_enable = REG_WDATA[HOST_IF_ENABLE_BIT];
            ctrl_d.onchip_ram_enable = REG_WDATA[ONCHIP_RAM_ENABLE_BIT];
        end
        rdata_d = rd_hit ? ctrl_q : 8'h00;
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_q <= SYSTEM_POWER_CONTROL_RESET;
            rdata_q <= 8'h00;
        end else begin
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------
    pdmc_state_e state_q, state_d;
    logic [17:0] cnt_q, cnt_d;
    logic done_q, done_d;
    logic [17:0] settle_target;

    // selector is read every settling cycle, so a late rewrite acts at once
    assign settle_target = settle_count(ctrl_q.wake_settle_select);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        unique case (state_q)
            PDMC_RUN: begin
                if (POWER_DOWN_EXEC) begin
                    state_d = ctrl_q.soft_standby_select ? PDMC_SSTBY
                                                         : PDMC_SLEEP;
                end
            end
            PDMC_SLEEP: begin
                if (IRQ_PENDING || !CHIP_RESET_PIN_N) begin
                    state_d = PDMC_RUN;
                end
            end
            PDMC_SSTBY: begin
                if (!CHIP_RESET_PIN_N) begin
                    state_d = PDMC_RUN;
                end else if (WAKE_EXT_IRQ) begin
                    state_d = PDMC_SETTLE;
                    cnt_d = 18'h00000;
                end
            end
            PDMC_SETTLE: begin
                if (!CHIP_RESET_PIN_N) begin
                    state_d = PDMC_RUN;
                end else begin
                    cnt_d = cnt_q + 18'h00001;
                    if (cnt_d >= settle_target) begin
                        state_d = PDMC_RUN;
                        done_d = 1'b1;
                    end
                end
            end
            PDMC_HSTBY: begin
                state_d = PDMC_RUN;
            end
            default: state_d = PDMC_RUN;
        endcase
        // hardware standby wins over every transition above
        if (!HW_STANDBY_PIN_N) begin
            state_d = PDMC_HSTBY;
            done_d = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= PDMC_RUN;
            cnt_q <= 18'h00000;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end

    // ------------------------------------------------------------
    // registered control outputs
    // ------------------------------------------------------------
    // bits: 0 cpu halt, 1 periph halt, 2 periph reset, 3 clock stop, 4 osc, 5 hiz
    // each bit is the final pin level, so every output comes straight from a flop
    logic [5:0] outs_q, outs_d;

    always_comb begin
        outs_d = 6'h10;
        unique case (state_d)
            PDMC_RUN: begin
                outs_d = 6'h10; // oscillator on, nothing held
            end
            PDMC_SLEEP: begin
                outs_d = 6'h11;
            end
            PDMC_SSTBY: begin
                outs_d = 6'h0f;
            end
            PDMC_SETTLE: begin
                outs_d = 6'h17;
            end
            PDMC_HSTBY: begin
                outs_d = 6'h2f;
            end
            default: begin
                outs_d = 6'h10;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            outs_q <= 6'h10;
        end else begin
            outs_q <= outs_d;
        end
    end

    always_comb begin
        CPU_HALT = outs_q[0];
        PERIPH_HALT = outs_q[1];
        PERIPH_RESET = outs_q[2];
        CLOCK_STOP = outs_q[3];
        OSC_ENABLE = outs_q[4];
        PORTS_HIZ = outs_q[5];
        WAKE_DONE = done_q;
        POWER_STATE = state_q;
        REG_RDATA = rdata_q;
    end

endmodule // pdmc_top

// file: sim/pdmc_cpu_model.sv
// partner model: cpu core requests and the reset and standby pins
module pdmc_cpu_model (
    input wire logic clk,
    output logic [2:0] req,
    output logic rst_n,
    output logic hw_standby_pin_n_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        req = 3'h0;
        rst_n = 1'b1;
        hw_standby_pin_n_n = 1'b1;
    end
    // bit 0 power-down, bit 1 sleep wake, bit 2 standby wake
    task automatic pulse(input logic [2:0] m);
        @(posedge clk) req <= m;
        @(posedge clk) req <= 3'h0;
    endtask
    task automatic pins(input logic r, input logic s);
        @(posedge clk) rst_n <= r;
        hw_standby_pin_n_n <= s;
    endtask
endmodule // pdmc_cpu_model

// file: sim/pdmc_properties.sv
// checker: power-down sequencing relations at the top ports
module pdmc_properties
    import pdmc_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic [15:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic POWER_DOWN_EXEC,
    input wire logic IRQ_PENDING,
    input wire logic WAKE_EXT_IRQ,
    input wire logic CHIP_RESET_PIN_N,
    input wire logic HW_STANDBY_PIN_N,
    input wire logic CPU_HALT,
    input wire logic CLOCK_STOP,
    input wire logic OSC_ENABLE,
    input wire logic PORTS_HIZ,
    input wire logic WAKE_DONE,
    input wire logic [4:0] POWER_STATE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    logic sel_q;
    logic pins;
    logic go;
    assign pins = CHIP_RESET_PIN_N && HW_STANDBY_PIN_N;
    assign go = POWER_STATE == PDMC_RUN && POWER_DOWN_EXEC && pins;
    // shadow of the standby-select bit, written only by software
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) sel_q <= 1'b0;
        else if (REG_WR && REG_ADDR == SYSTEM_POWER_CONTROL_ADDR) sel_q <= REG_WDATA[7];
    end
    property p_slp; go && !sel_q |=> POWER_STATE == PDMC_SLEEP && CPU_HALT; endproperty
    a_slp: assert property (p_slp) else $error("sleep entry");
    property p_sst; go && sel_q |=> POWER_STATE == PDMC_SSTBY; endproperty
    a_sst: assert property (p_sst) else $error("standby entry");
    property p_one; $onehot(POWER_STATE); endproperty
    a_one: assert property (p_one) else $error("state code");
    property p_stl; POWER_STATE == PDMC_SETTLE |-> OSC_ENABLE && CPU_HALT && !CLOCK_STOP;
    endproperty
    a_stl: assert property (p_stl) else $error("settle outputs");
    property p_off; POWER_STATE == PDMC_SSTBY |-> CLOCK_STOP && !OSC_ENABLE && CPU_HALT;
    endproperty
    a_off: assert property (p_off) else $error("standby outputs");
    property p_swk; POWER_STATE == PDMC_SLEEP && pins && IRQ_PENDING |=> POWER_STATE == PDMC_RUN;
    endproperty
    a_swk: assert property (p_swk) else $error("sleep exit");
    property p_xwk; POWER_STATE == PDMC_SSTBY && pins && WAKE_EXT_IRQ |=> POWER_STATE == PDMC_SETTLE;
    endproperty
    a_xwk: assert property (p_xwk) else $error("standby exit");
    property p_hw; !HW_STANDBY_PIN_N |=> POWER_STATE == PDMC_HSTBY && PORTS_HIZ; endproperty
    a_hw: assert property (p_hw) else $error("hw standby");
    property p_dn; WAKE_DONE |-> POWER_STATE == PDMC_RUN && $past(POWER_STATE) == PDMC_SETTLE;
    endproperty
    a_dn: assert property (p_dn) else $error("settle done");
endmodule // pdmc_properties

// file: sim/tb.sv
// testbench: register, sleep, standby settling and hardware standby
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin err_total++; \
    $display("Error %s exp %h got %h", n, e, a); end end
module tb;
    import pdmc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] A = SYSTEM_POWER_CONTROL_ADDR;
    logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, halt, hiz, done;
    logic rsrc = 1'b1, phalt, prst, cstop, osc, rst_pin_n, hw_standby_pin_n_pin_n;
    logic [2:0] req;
    logic [5:0] outs;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wd = 8'h00, rdat;
    logic [4:0] st;
    int err_total = 0, comparisons = 0;
    assign outs = {hiz, osc, cstop, prst, phalt, halt};
    pdmc_cpu_model m (.clk(clk), .req(req), .rst_n(rst_pin_n), .hw_standby_pin_n_n(hw_standby_pin_n_pin_n));
    pdmc_top #(.FLASH_VARIANT(1'b1)) dut (.SYS_CLK(clk), .ARST_N(arst_n), .REG_ADDR(addr),
        .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat),
        .POWER_DOWN_EXEC(req[0]), .IRQ_PENDING(req[1]), .WAKE_EXT_IRQ(req[2]),
        .CHIP_RESET_PIN_N(rst_pin_n), .HW_STANDBY_PIN_N(hw_standby_pin_n_pin_n), .RESET_SOURCE_IN(rsrc),
        .CPU_HALT(halt), .PERIPH_HALT(phalt), .PERIPH_RESET(prst), .CLOCK_STOP(cstop),
        .OSC_ENABLE(osc), .PORTS_HIZ(hiz), .WAKE_DONE(done), .POWER_STATE(st));
    initial forever #10 clk = ~clk;
    task automatic end_sim();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) {addr, wd, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 1'b0;
        #1 `CHK("rdata", e, rdat)
    endtask
    task automatic s_reg();
        rd_chk(A, SYSTEM_POWER_CONTROL_RESET);
        wr_reg(A, 8'h76);
        rd_chk(A, 8'h7e);
        wr_reg(16'hffc5, 8'h00);
        rd_chk(16'hffc5, 8'h00);
        rd_chk(A, 8'h7e);
        @(posedge clk) #1 `CHK("rdata idle", 8'h00, rdat)
        @(posedge clk) rsrc <= 1'b0;
        rd_chk(A, 8'h76);
        @(posedge clk) rsrc <= 1'b1;
    endtask
    task automatic s_sleep();
        wr_reg(A, 8'h09);
        m.pulse(3'h1);
        #1 `CHK("sleep", PDMC_SLEEP, st)
        `CHK("halt", 1'b1, halt)
        `CHK("sleep outs", 6'h11, outs)
        m.pulse(3'h2);
        #1 `CHK("irq wake", PDMC_RUN, st)
        `CHK("run outs", 6'h10, outs)
        m.pulse(3'h1);
        #1 `CHK("sleep again", PDMC_SLEEP, st)
        m.pins(1'b0, 1'b1);
        @(posedge clk) #1 `CHK("reset wake", PDMC_RUN, st)
        m.pins(1'b1, 1'b1);
    endtask
    task automatic s_settle(input logic [2:0] code, input logic [17:0] n);
        logic [17:0] c;
        wr_reg(A, {1'b1, code, 4'h1});
        m.pulse(3'h1);
        #1 `CHK("standby", PDMC_SSTBY, st)
        `CHK("standby outs", 6'h0f, outs)
        m.pulse(3'h4);
        #1 `CHK("settle", PDMC_SETTLE, st)
        `CHK("settle outs", 6'h17, outs)
        for (c = 18'h00001; c < n + 18'h00010 && st === PDMC_SETTLE; c++) @(posedge clk) #1;
        `CHK("count", n, c - 18'h00001)
        `CHK("done", 1'b1, done)
        `CHK("wake outs", 6'h10, outs)
        if (st === PDMC_SETTLE) end_sim();
        @(posedge clk) #1 `CHK("done pulse", 1'b0, done)
        rd_chk(A, {1'b1, code, 4'h9});
        wr_reg(A, 8'h09);
    endtask
    task automatic s_hw();
        wr_reg(A, 8'h89);
        m.pulse(3'h1);
        #1 `CHK("standby", PDMC_SSTBY, st)
        m.pins(1'b1, 1'b0);
        @(posedge clk) #1 `CHK("hw standby", PDMC_HSTBY, st)
        `CHK("hiz", 1'b1, hiz)
        `CHK("hw outs", 6'h2f, outs)
        m.pins(1'b1, 1'b1);
        @(posedge clk) #1 `CHK("hw exit", PDMC_RUN, st)
        wr_reg(A, 8'h09);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        s_reg();
        s_sleep();
        s_settle(3'h5, SETTLE_1K);
        s_settle(3'h0, SETTLE_8K);
        s_hw();
        end_sim();
    end
endmodule // tb
bind pdmc_top pdmc_properties u_chk (
    .SYS_CLK(SYS_CLK),
    .ARST_N(ARST_N),
    .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR),
    .POWER_DOWN_EXEC(POWER_DOWN_EXEC),
    .IRQ_PENDING(IRQ_PENDING),
    .WAKE_EXT_IRQ(WAKE_EXT_IRQ),
    .CHIP_RESET_PIN_N(CHIP_RESET_PIN_N),
    .HW_STANDBY_PIN_N(HW_STANDBY_PIN_N),
    .CPU_HALT(CPU_HALT),
    .CLOCK_STOP(CLOCK_STOP),
    .OSC_ENABLE(OSC_ENABLE),
    .PORTS_HIZ(PORTS_HIZ),
    .WAKE_DONE(WAKE_DONE),
    .POWER_STATE(POWER_STATE)
);
